// ==== hdl/branch_pkg.sv ====
/*
 * Shared constants and types for the branch and skip condition unit:
 * instruction selector, status flag positions, cycle counts and
 * program counter steps.
 * Assumes nothing of its surroundings; every user names it explicitly.
 */
package branch_pkg;

    // ************************************************************
    // Instruction selector
    // ************************************************************
    typedef enum logic [4:0] {
        SKIP_IO_BIT_CLEAR,
        SKIP_IO_BIT_SET,
        BRANCH_FLAG_SET,
        BRANCH_FLAG_CLEAR,
        BRANCH_EQUAL,
        BRANCH_NOT_EQUAL,
        BRANCH_CARRY_SET,
        BRANCH_CARRY_CLEAR,
        BRANCH_SAME_OR_HIGHER,
        BRANCH_LOWER,
        BRANCH_MINUS,
        BRANCH_PLUS,
        BRANCH_SIGNED_GE,
        BRANCH_SIGNED_LT,
        BRANCH_HALF_CARRY_SET,
        BRANCH_HALF_CARRY_CLEAR,
        BRANCH_TRANSFER_SET,
        BRANCH_TRANSFER_CLEAR
    } op_t;

    // ************************************************************
    // Status flag positions
    // ************************************************************
    localparam logic [2:0] FLAG_C = 3'h0;
    localparam logic [2:0] FLAG_Z = 3'h1;
    localparam logic [2:0] FLAG_N = 3'h2;
    localparam logic [2:0] FLAG_V = 3'h3;
    localparam logic [2:0] FLAG_H = 3'h5;
    localparam logic [2:0] FLAG_T = 3'h6;

    // ************************************************************
    // Cycle counts and program counter steps (in words)
    // ************************************************************
    localparam logic [1:0] CYC_UNTAKEN = 2'h1;
    localparam logic [1:0] CYC_BRANCH = 2'h2;
    localparam logic [1:0] CYC_SKIP_ONE = 2'h2;
    localparam logic [1:0] CYC_SKIP_TWO = 2'h3;
    localparam logic [1:0] STEP_SEQ = 2'h1;
    localparam logic [1:0] STEP_SKIP_ONE = 2'h2;
    localparam logic [1:0] STEP_SKIP_TWO = 2'h3;

    // Default widths and reset values
    localparam int PC_W_DEF = 16;
    localparam int OFS_W_DEF = 7;
    localparam logic RST_FLAG = 1'h0;

endpackage

// ==== hdl/branch_skip_condition_unit.sv ====
/*
 * Branch and skip condition unit of an 8-bit core: evaluates the skip and
 * relative branch conditions, spends the documented cycles, and delivers the
 * new program counter. Status flags are never written.
 * Assumes the fetch logic presents one instruction with instr_valid, holds
 * its fields for that cycle only, and waits for done before relying on
 * pc_next. All inputs are synchronous to clk_sys.
 */
`timescale 1ns/1ps
`default_nettype none

module branch_skip_condition_unit #(
    parameter int PC_W = branch_pkg::PC_W_DEF,
    parameter int OFS_W = branch_pkg::OFS_W_DEF
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic instr_valid,
    input wire branch_pkg::op_t op,
    input wire logic [2:0] sel,
    input wire logic [OFS_W-1:0] offset,
    input wire logic [7:0] io_data,
    input wire logic [7:0] status_flags,
    input wire logic [PC_W-1:0] pc_now,
    input wire logic next_two_word,
    output logic busy,
    output logic done,
    output logic taken,
    output logic flags_we,
    output logic [PC_W-1:0] pc_next
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    // The offset must fit inside the counter for the sign extension to hold
    if (PC_W < 8 || PC_W > 24 || OFS_W < 2 || OFS_W >= PC_W) begin : g_bad_width
        $error("branch_skip_condition_unit: unsupported PC_W or OFS_W");
    end

    // ************************************************************
    // Condition evaluation and target
    // ************************************************************
    typedef enum logic {ST_IDLE, ST_EXEC} state_t;

    state_t state;
    state_t next_state;
    logic [1:0] remain;
    logic [1:0] next_remain;
    logic next_busy;
    logic next_done;
    logic next_taken;
    logic next_flags_we;
    logic [PC_W-1:0] next_pc;
    logic [PC_W-1:0] step_target;
    logic [1:0] step_cycles;
    logic accept;

    decision_if dec ();

    // Fields go straight to the evaluator; only the outcome is registered
    assign dec.op = op;
    assign dec.flags = status_flags;
    assign dec.io_data = io_data;
    assign dec.sel = sel;

    cond_eval u_eval (
        .port(dec.eval)
    );

    pc_step #(
        .PC_W(PC_W),
        .OFS_W(OFS_W)
    ) u_step (
        .pc(pc_now),
        .offset(offset),
        .is_skip(dec.is_skip),
        .take(dec.take),
        .two_word(next_two_word),
        .target(step_target),
        .cycles(step_cycles)
    );

    // Requests are only looked at when idle; a busy unit ignores them
    assign accept = instr_valid && (state == ST_IDLE);

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Decision and target are latched at acceptance, so the fetch side may
    // change its fields right after; extra cycles are only waited out
    always_comb begin
        next_state = state;
        next_remain = remain;
        next_busy = busy;
        next_done = 1'b0;
        next_taken = taken;
        next_pc = pc_next;
        next_flags_we = branch_pkg::RST_FLAG;
        case (state)
            ST_IDLE: begin
                if (accept) begin
                    next_taken = dec.take;
                    next_pc = step_target;
                    if (step_cycles == branch_pkg::CYC_UNTAKEN) begin
                        next_done = 1'b1;
                    end else begin
                        next_state = ST_EXEC;
                        next_busy = 1'b1;
                        next_remain = step_cycles - branch_pkg::CYC_BRANCH;
                    end
                end
            end
            ST_EXEC: begin
                if (remain == 2'h0) begin
                    next_state = ST_IDLE;
                    next_busy = 1'b0;
                    next_done = 1'b1;
                end else begin
                    next_remain = remain - 2'h1;
                end
            end
            default: begin
                next_state = ST_IDLE;
                next_busy = 1'b0;
            end
        endcase
    end

    // Registers only; every output comes from here
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            state <= ST_IDLE;
            remain <= 2'h0;
            busy <= branch_pkg::RST_FLAG;
            done <= branch_pkg::RST_FLAG;
            taken <= branch_pkg::RST_FLAG;
            flags_we <= branch_pkg::RST_FLAG;
            pc_next <= '0;
        end else begin
            state <= next_state;
            remain <= next_remain;
            busy <= next_busy;
            done <= next_done;
            taken <= next_taken;
            flags_we <= next_flags_we;
            pc_next <= next_pc;
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    // Helper copies of the accepted fields, read only by the checks below
    logic [PC_W-1:0] acc_pc;
    logic [OFS_W-1:0] acc_ofs;
    logic [PC_W-1:0] rel_target;
    logic [PC_W-1:0] seq_target;

    always_ff @(posedge clk_sys) begin
        if (accept) begin
            acc_pc <= pc_now;
            acc_ofs <= offset;
        end
    end

    assign rel_target = acc_pc + PC_W'($signed(acc_ofs)) + PC_W'(1);
    assign seq_target = acc_pc + PC_W'(1);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);

    // Taken branch: one busy cycle, then done with the relative target
    sequence s_branch_taken;
        busy && !done ##1 (done && taken && !busy && pc_next == rel_target);
    endsequence

    // Fall through: done in the very next cycle with the next address
    sequence s_fall;
        done && !taken && !busy && pc_next == seq_target;
    endsequence

    // Taken one-word skip: busy one cycle, done at pc plus two
    sequence s_skip_one;
        busy ##1 (done && taken && pc_next == acc_pc + PC_W'(2));
    endsequence

    // Taken two-word skip: busy two cycles, done at pc plus three
    sequence s_skip_two;
        busy && !done [*2] ##1 (done && taken && pc_next == acc_pc + PC_W'(3));
    endsequence

    io_clear_skip_a: assert property (
        accept && op == branch_pkg::SKIP_IO_BIT_CLEAR && !io_data[sel] && !next_two_word
        |-> ##1 s_skip_one)
        else $error("clear-bit skip did not skip one word in two cycles");

    io_set_skip_a: assert property (
        accept && op == branch_pkg::SKIP_IO_BIT_SET && io_data[sel] && next_two_word
        |-> ##1 s_skip_two)
        else $error("set-bit skip did not skip a two-word instruction in three cycles");

    skip_fall_a: assert property (
        accept && op == branch_pkg::SKIP_IO_BIT_SET && !io_data[sel] |-> ##1 s_fall)
        else $error("skip with false condition did not continue in sequence");

    flag_set_branch_a: assert property (
        accept && op == branch_pkg::BRANCH_FLAG_SET && status_flags[sel]
        |-> ##1 s_branch_taken)
        else $error("flag-set branch missed its relative target");

    flag_clear_fall_a: assert property (
        accept && op == branch_pkg::BRANCH_FLAG_CLEAR && status_flags[sel] |-> ##1 s_fall)
        else $error("flag-clear branch taken with flag set");

    equal_branch_a: assert property (
        accept && op == branch_pkg::BRANCH_EQUAL
        |-> ##1 (taken == $past(status_flags[branch_pkg::FLAG_Z])))
        else $error("equal branch decision does not follow the zero flag");

    carry_pair_a: assert property (
        accept && (op == branch_pkg::BRANCH_CARRY_SET || op == branch_pkg::BRANCH_LOWER)
        && status_flags[branch_pkg::FLAG_C] |-> ##1 s_branch_taken)
        else $error("carry-set branch not taken with carry set");

    same_higher_a: assert property (
        accept && op == branch_pkg::BRANCH_SAME_OR_HIGHER
        && status_flags[branch_pkg::FLAG_C] |-> ##1 s_fall)
        else $error("same-or-higher branch taken with carry set");

    signed_ge_a: assert property (
        accept && op == branch_pkg::BRANCH_SIGNED_GE
        && (status_flags[branch_pkg::FLAG_N] ^ status_flags[branch_pkg::FLAG_V])
        |-> ##1 s_fall)
        else $error("signed greater-or-equal taken with N xor V set");

    signed_lt_a: assert property (
        accept && op == branch_pkg::BRANCH_SIGNED_LT
        && (status_flags[branch_pkg::FLAG_N] ^ status_flags[branch_pkg::FLAG_V])
        |-> ##1 s_branch_taken ##0 !flags_we)
        else $error("signed less-than not taken or wrote flags");

    half_clear_a: assert property (
        accept && op == branch_pkg::BRANCH_HALF_CARRY_CLEAR
        && !status_flags[branch_pkg::FLAG_H] |-> ##1 s_branch_taken)
        else $error("half-carry-clear branch not taken with H clear");

    transfer_set_a: assert property (
        accept && op == branch_pkg::BRANCH_TRANSFER_SET
        && !status_flags[branch_pkg::FLAG_T] |-> ##1 s_fall)
        else $error("transfer-set branch taken with T clear");

    // Named branches not covered above except carry clear, one polarity each
    not_equal_a: assert property (
        accept && op == branch_pkg::BRANCH_NOT_EQUAL && !status_flags[branch_pkg::FLAG_Z]
        |-> ##1 s_branch_taken)
        else $error("not-equal branch not taken with Z clear");

    minus_fall_a: assert property (
        accept && op == branch_pkg::BRANCH_MINUS && !status_flags[branch_pkg::FLAG_N]
        |-> ##1 s_fall)
        else $error("minus branch taken with N clear");

    plus_branch_a: assert property (
        accept && op == branch_pkg::BRANCH_PLUS && !status_flags[branch_pkg::FLAG_N]
        |-> ##1 s_branch_taken)
        else $error("plus branch not taken with N clear");

    half_set_a: assert property (
        accept && op == branch_pkg::BRANCH_HALF_CARRY_SET && !status_flags[branch_pkg::FLAG_H]
        |-> ##1 s_fall)
        else $error("half-carry-set branch taken with H clear");

    transfer_clear_a: assert property (
        accept && op == branch_pkg::BRANCH_TRANSFER_CLEAR && !status_flags[branch_pkg::FLAG_T]
        |-> ##1 s_branch_taken)
        else $error("transfer-clear branch not taken with T clear");

    // A request offered while busy must leave the latched outcome alone
    busy_refuse_a: assert property (
        busy |-> ##1 ($stable(taken) && $stable(pc_next)))
        else $error("request accepted while busy");

endmodule

`default_nettype wire

// ==== hdl/cond_eval.sv ====
/*
 * Condition evaluator: decides from the selector, the status flags and the
 * addressed I/O value whether the instruction is taken.
 * Assumes inputs are stable in the cycle they are looked at; no state.
 */
`timescale 1ns/1ps
`default_nettype none

module cond_eval (
    decision_if.eval port
);

    // Signed compare outcome, shared by the two signed branches
    logic n_xor_v;
    assign n_xor_v = port.flags[branch_pkg::FLAG_N] ^ port.flags[branch_pkg::FLAG_V];

    // ************************************************************
    // Condition decode
    // ************************************************************
    // Purely combinational; the core registers the outcome
    always_comb begin
        port.take = 1'b0;
        port.is_skip = 1'b0;
        case (port.op)
            branch_pkg::SKIP_IO_BIT_CLEAR: begin
                port.is_skip = 1'b1;
                port.take = !port.io_data[port.sel];
            end
            branch_pkg::SKIP_IO_BIT_SET: begin
                port.is_skip = 1'b1;
                port.take = port.io_data[port.sel];
            end
            branch_pkg::BRANCH_FLAG_SET: port.take = port.flags[port.sel];
            branch_pkg::BRANCH_FLAG_CLEAR: port.take = !port.flags[port.sel];
            branch_pkg::BRANCH_EQUAL: port.take = port.flags[branch_pkg::FLAG_Z];
            branch_pkg::BRANCH_NOT_EQUAL: port.take = !port.flags[branch_pkg::FLAG_Z];
            branch_pkg::BRANCH_CARRY_SET,
            branch_pkg::BRANCH_LOWER: port.take = port.flags[branch_pkg::FLAG_C];
            branch_pkg::BRANCH_CARRY_CLEAR,
            branch_pkg::BRANCH_SAME_OR_HIGHER: port.take = !port.flags[branch_pkg::FLAG_C];
            branch_pkg::BRANCH_MINUS: port.take = port.flags[branch_pkg::FLAG_N];
            branch_pkg::BRANCH_PLUS: port.take = !port.flags[branch_pkg::FLAG_N];
            branch_pkg::BRANCH_SIGNED_GE:
                port.take = !n_xor_v;
            branch_pkg::BRANCH_SIGNED_LT:
                port.take = n_xor_v;
            branch_pkg::BRANCH_HALF_CARRY_SET: port.take = port.flags[branch_pkg::FLAG_H];
            branch_pkg::BRANCH_HALF_CARRY_CLEAR:
                port.take = !port.flags[branch_pkg::FLAG_H];
            branch_pkg::BRANCH_TRANSFER_SET: port.take = port.flags[branch_pkg::FLAG_T];
            branch_pkg::BRANCH_TRANSFER_CLEAR: port.take = !port.flags[branch_pkg::FLAG_T];
            default: port.take = 1'b0;
        endcase
    end

endmodule

`default_nettype wire

// ==== hdl/decision_if.sv ====
/*
 * Carrier between the sequencing core and the condition evaluator.
 * Assumes both ends sit in the same clock domain; it is purely combinational.
 */
`timescale 1ns/1ps
`default_nettype none

interface decision_if;
    branch_pkg::op_t op;
    logic [7:0] flags;
    logic [7:0] io_data;
    logic [2:0] sel;
    logic take;
    logic is_skip;

    modport core (output op, output flags, output io_data, output sel,
                  input take, input is_skip);
    modport eval (input op, input flags, input io_data, input sel,
                  output take, output is_skip);
endinterface

`default_nettype wire

// ==== hdl/pc_step.sv ====
/*
 * Program counter step: next address and cycle cost of a decided
 * instruction. Addresses are in words and wrap at the counter width.
 * Assumes the decision comes from the condition evaluator in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module pc_step #(
    parameter int PC_W = branch_pkg::PC_W_DEF,
    parameter int OFS_W = branch_pkg::OFS_W_DEF
) (
    input wire logic [PC_W-1:0] pc,
    input wire logic [OFS_W-1:0] offset,
    input wire logic is_skip,
    input wire logic take,
    input wire logic two_word,
    output logic [PC_W-1:0] target,
    output logic [1:0] cycles
);

    // Widens a small step to the counter width
    function automatic logic [PC_W-1:0] widen(input logic [1:0] step);
        return PC_W'(step);
    endfunction

    // ************************************************************
    // Target and cost
    // ************************************************************
    // Offset is signed two's complement; the sum wraps like the real counter
    always_comb begin
        if (!take) begin
            target = pc + widen(branch_pkg::STEP_SEQ);
            cycles = branch_pkg::CYC_UNTAKEN;
        end else if (is_skip && two_word) begin
            target = pc + widen(branch_pkg::STEP_SKIP_TWO);
            cycles = branch_pkg::CYC_SKIP_TWO;
        end else if (is_skip) begin
            target = pc + widen(branch_pkg::STEP_SKIP_ONE);
            cycles = branch_pkg::CYC_SKIP_ONE;
        end else begin
            target = pc + PC_W'($signed(offset)) + widen(branch_pkg::STEP_SEQ);
            cycles = branch_pkg::CYC_BRANCH;
        end
    end

endmodule

`default_nettype wire

// ==== testbench/branch_skip_condition_unit_tb_top.sv ====
/*
 * Self-checking bench for the branch and skip condition unit.
 * Assumes the core side model drives flags and I/O data; the bench drives
 * the instruction fields 1 ns after each rising edge.
 */
`timescale 1ns/1ps
`default_nettype none

`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin num_errors++; \
    $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); end end

module branch_skip_condition_unit_tb_top;
    // ************************************************************
    // Signals and instances
    // ************************************************************
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic instr_valid = 1'b0;
    branch_pkg::op_t op = branch_pkg::BRANCH_EQUAL;
    logic [2:0] sel = 3'h0;
    logic [6:0] offset = 7'h00;
    logic [15:0] pc_now = 16'h0000;
    logic next_two_word = 1'b0;
    logic load = 1'b0;
    logic [7:0] load_flags = 8'h00;
    logic [7:0] load_io = 8'h00;
    logic [7:0] io_data;
    logic [7:0] status_flags;
    logic busy, done, taken, flags_we;
    logic [15:0] pc_next;
    int num_errors = 0;
    int check_count = 0;

    always #5 clk_sys = ~clk_sys;

    core_side_model partner (.clk_sys(clk_sys), .rst(rst), .load(load),
        .load_flags(load_flags), .load_io(load_io), .flags_we(flags_we),
        .status_flags(status_flags), .io_data(io_data));

    branch_skip_condition_unit #(.PC_W(16), .OFS_W(7)) uut (.clk_sys(clk_sys),
        .rst(rst), .instr_valid(instr_valid), .op(op), .sel(sel), .offset(offset),
        .io_data(io_data), .status_flags(status_flags), .pc_now(pc_now),
        .next_two_word(next_two_word), .busy(busy), .done(done), .taken(taken),
        .flags_we(flags_we), .pc_next(pc_next));

    // ************************************************************
    // Shared helpers
    // ************************************************************
    task automatic end_sim;
        if (num_errors == 0 && check_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Expected decision, worked out independently of the design
    function automatic logic exp_take(branch_pkg::op_t o, logic [2:0] s,
                                      logic [7:0] io, logic [7:0] f);
        logic nv;
        nv = f[branch_pkg::FLAG_N] ^ f[branch_pkg::FLAG_V];
        case (o)
            branch_pkg::SKIP_IO_BIT_CLEAR: exp_take = ~io[s];
            branch_pkg::SKIP_IO_BIT_SET: exp_take = io[s];
            branch_pkg::BRANCH_FLAG_SET: exp_take = f[s];
            branch_pkg::BRANCH_FLAG_CLEAR: exp_take = ~f[s];
            branch_pkg::BRANCH_EQUAL: exp_take = f[branch_pkg::FLAG_Z];
            branch_pkg::BRANCH_NOT_EQUAL: exp_take = ~f[branch_pkg::FLAG_Z];
            branch_pkg::BRANCH_CARRY_SET, branch_pkg::BRANCH_LOWER: exp_take = f[0];
            branch_pkg::BRANCH_CARRY_CLEAR, branch_pkg::BRANCH_SAME_OR_HIGHER: exp_take = ~f[0];
            branch_pkg::BRANCH_MINUS: exp_take = f[branch_pkg::FLAG_N];
            branch_pkg::BRANCH_PLUS: exp_take = ~f[branch_pkg::FLAG_N];
            branch_pkg::BRANCH_SIGNED_GE: exp_take = ~nv;
            branch_pkg::BRANCH_SIGNED_LT: exp_take = nv;
            branch_pkg::BRANCH_HALF_CARRY_SET: exp_take = f[branch_pkg::FLAG_H];
            branch_pkg::BRANCH_HALF_CARRY_CLEAR: exp_take = ~f[branch_pkg::FLAG_H];
            branch_pkg::BRANCH_TRANSFER_SET: exp_take = f[branch_pkg::FLAG_T];
            branch_pkg::BRANCH_TRANSFER_CLEAR: exp_take = ~f[branch_pkg::FLAG_T];
            default: exp_take = 1'b0;
        endcase
    endfunction

    // Load flags and I/O, issue one instruction, judge cycles, target, flags
    task automatic run_op(input branch_pkg::op_t o, input logic [2:0] s,
                          input logic [6:0] ofs, input logic [7:0] io,
                          input logic [7:0] f, input logic [15:0] pc, input logic tw);
        logic tk;
        logic skp;
        logic [15:0] epc;
        int ecyc;
        int n;
        tk = exp_take(o, s, io, f);
        skp = (o == branch_pkg::SKIP_IO_BIT_CLEAR) || (o == branch_pkg::SKIP_IO_BIT_SET);
        if (!tk) begin
            epc = pc + 16'h0001;
            ecyc = 1;
        end else if (skp) begin
            epc = pc + (tw ? 16'h0003 : 16'h0002);
            ecyc = tw ? 3 : 2;
        end else begin
            epc = pc + {{9{ofs[6]}}, ofs} + 16'h0001;
            ecyc = 2;
        end
        load_flags = f;
        load_io = io;
        load = 1'b1;
        @(posedge clk_sys); #1;
        load = 1'b0;
        instr_valid = 1'b1;
        op = o;
        sel = s;
        offset = ofs;
        pc_now = pc;
        next_two_word = tw;
        @(posedge clk_sys); #1;
        instr_valid = 1'b0;
        n = 1;
        while (done !== 1'b1 && n < 6) begin
            @(posedge clk_sys); #1;
            n++;
        end
        if (done !== 1'b1) begin
            num_errors++;
            end_sim();
        end
        `CHK(n, ecyc)
        `CHK(taken, tk)
        `CHK(pc_next, epc)
        `CHK(status_flags, f)
        `CHK(flags_we, 1'b0)
    endtask

    // ************************************************************
    // Scenarios
    // ************************************************************
    // Outputs settle to zero under reset
    task automatic t_reset_values;
        `CHK({busy, done, taken, flags_we}, 4'h0)
        `CHK(pc_next, 16'h0000)
    endtask

    // Every I/O bit, both polarities, one- and two-word neighbours
    task automatic t_skips;
        logic [2:0] b;
        logic w;
        for (int k = 0; k < 16; k++) begin
            b = k[2:0];
            w = k[3];
            run_op(branch_pkg::SKIP_IO_BIT_CLEAR, b, 7'h00, 8'hA5, 8'hC3, 16'h0040, w);
            run_op(branch_pkg::SKIP_IO_BIT_SET, b, 7'h00, 8'hA5, 8'hC3, 16'h0040, w);
        end
        run_op(branch_pkg::SKIP_IO_BIT_SET, 3'h7, 7'h00, 8'h80, 8'h00, 16'hFFFE, 1'b1);
    endtask

    // Generic flag branches over every flag index
    task automatic t_flag_branches;
        logic [2:0] b;
        for (int s = 0; s < 8; s++) begin
            b = s[2:0];
            run_op(branch_pkg::BRANCH_FLAG_SET, b, 7'h7F, 8'h00, 8'h55, 16'h0200, 1'b0);
            run_op(branch_pkg::BRANCH_FLAG_CLEAR, b, 7'h7F, 8'h00, 8'h55, 16'h0200, 1'b0);
        end
    endtask

    // Each named branch against single flags, none and all
    task automatic t_named_branches;
        logic [7:0] fl [8] = '{8'h00, 8'hFF, 8'h01, 8'h02, 8'h04, 8'h08, 8'h20, 8'h40};
        branch_pkg::op_t o;
        for (int i = 4; i < 18; i++) begin
            o = branch_pkg::op_t'(i);
            for (int j = 0; j < 8; j++) begin
                if (i < 10) begin
                    run_op(o, 3'h0, 7'h0A, 8'h00, fl[j], 16'h1000, 1'b0);
                end else if (i < 14) begin
                    run_op(o, 3'h0, 7'h0A, 8'h00, fl[j], 16'h1000, 1'b0);
                end else begin
                    run_op(o, 3'h0, 7'h0A, 8'h00, fl[j], 16'h1000, 1'b0);
                end
            end
        end
    endtask

    // Extreme offsets and wrap of the counter
    task automatic t_offsets;
        run_op(branch_pkg::BRANCH_EQUAL, 3'h0, 7'h01, 8'h00, 8'h02, 16'hFFFE, 1'b0);
        run_op(branch_pkg::BRANCH_EQUAL, 3'h0, 7'h40, 8'h00, 8'h02, 16'h0010, 1'b0);
        run_op(branch_pkg::BRANCH_NOT_EQUAL, 3'h0, 7'h3F, 8'h00, 8'h00, 16'h0010, 1'b0);
    endtask

    // Untaken branches one per cycle; the second is offered in the done cycle
    task automatic t_back_to_back;
        load_flags = 8'h00;
        load = 1'b1;
        @(posedge clk_sys); #1;
        load = 1'b0;
        instr_valid = 1'b1;
        op = branch_pkg::BRANCH_EQUAL;
        pc_now = 16'h0100;
        @(posedge clk_sys); #1;
        pc_now = 16'h0200;
        `CHK({done, taken}, 2'h2)
        `CHK(pc_next, 16'h0101)
        @(posedge clk_sys); #1;
        instr_valid = 1'b0;
        `CHK({done, taken}, 2'h2)
        `CHK(pc_next, 16'h0201)
    endtask

    // A request held during the extra cycle of a taken branch leaves no trace
    task automatic t_busy_ignore;
        load_flags = 8'h00;
        load = 1'b1;
        @(posedge clk_sys); #1;
        load = 1'b0;
        instr_valid = 1'b1;
        op = branch_pkg::BRANCH_NOT_EQUAL;
        offset = 7'h05;
        pc_now = 16'h0300;
        @(posedge clk_sys); #1;
        pc_now = 16'h0400;
        `CHK({busy, done}, 2'h2)
        @(posedge clk_sys); #1;
        instr_valid = 1'b0;
        `CHK({busy, done, taken}, 3'h3)
        @(posedge clk_sys); #1;
        `CHK(done, 1'b0)
        `CHK(pc_next, 16'h0306)
    endtask

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge clk_sys);
        #1;
        t_reset_values();
        rst = 1'b0;
        t_skips();
        t_flag_branches();
        t_named_branches();
        t_offsets();
        t_back_to_back();
        t_busy_ignore();
        end_sim();
    end
endmodule

`default_nettype wire

// ==== testbench/core_side_model.sv ====
/*
 * Model of the core around the condition unit: status flag register and
 * the addressed I/O register, both loaded by the bench through a strobe.
 * Assumes one clock, synchronous active-high reset, like the unit itself.
 */
`timescale 1ns/1ps
`default_nettype none

module core_side_model (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic load,
    input wire logic [7:0] load_flags,
    input wire logic [7:0] load_io,
    input wire logic flags_we,
    output logic [7:0] status_flags,
    output logic [7:0] io_data
);
    // ************************************************************
    // Register state
    // ************************************************************
    logic [7:0] next_status_flags;
    logic [7:0] next_io_data;

    // A stray write strobe corrupts the flags, so the bench sees any write
    always_comb begin
        next_status_flags = status_flags;
        next_io_data = io_data;
        if (load) begin
            next_status_flags = load_flags;
            next_io_data = load_io;
        end else if (flags_we) begin
            next_status_flags = ~status_flags;
        end
    end

    // Registers only
    always_ff @(posedge clk_sys) begin
        if (rst) begin
            status_flags <= 8'h00;
            io_data <= 8'h00;
        end else begin
            status_flags <= next_status_flags;
            io_data <= next_io_data;
        end
    end
endmodule

`default_nettype wire
